// file: mce_pkg.sv
// Package: constants and carriers for the error bank logic
//------------------------------------------------------------
//------------------------------------------------------------
package mce_pkg;
	localparam int NUM_BANKS  = 4;
	localparam int BANK_W     = 2;
	localparam int ADDR_W     = 32;
	localparam int MISC_W     = 32;
	localparam int CODE_W     = 16;
	localparam int STAT_W     = 24;
	localparam int GSTAT_W    = 3;
	// Bank status field positions
	localparam int ST_VALID   = 23;
	localparam int ST_OVER    = 22;
	localparam int ST_UNCORR  = 21;
	localparam int ST_MISC_VALID   = 20;
	localparam int ST_ADDRESS_VALID   = 19;
	localparam int ST_PCC     = 18;
	localparam int ST_CODE_LO = 0;
	// Global status field positions
	localparam int GS_RESTART_IP_VALID    = 0;
	localparam int GS_EIPV    = 1;
	localparam int GS_CHECK_IN_PROGRESS    = 2;
	// Reset values and bank count
	localparam logic [STAT_W-1:0]  STAT_RST  = 24'h000000;
	localparam logic [GSTAT_W-1:0] GSTAT_RST = 3'h0;
	localparam logic [7:0]         CAP_COUNT = 8'(NUM_BANKS);

	// One detected error as reported by the core
	typedef struct packed {
		logic              uncorr;
		logic              context_corrupt;
		logic              addr_ok;
		logic              misc_ok;
		logic [CODE_W-1:0] code;
		logic [ADDR_W-1:0] addr;
		logic [MISC_W-1:0] misc;
	} err_rpt_t;

	// Restart context of the interrupted program
	typedef struct packed {
		logic restart_ip_valid;
		logic eipv;
	} ctx_t;
endpackage

// file: mce_bank.sv
// One error-reporting bank: status, address and misc registers
`timescale 1ns/1ps
`default_nettype none
module mce_bank
	import mce_pkg::*;
(
	// Clock, reset, enable
	input  wire logic              clk,
	input  wire logic              arst_n,
	input  wire logic              ce,
	// Error capture
	input  wire logic              log_en,
	input  wire err_rpt_t          rpt,
	// Software clear of this bank
	input  wire logic              clr,
	// Contents
	output logic [STAT_W-1:0]      status_reg,
	output logic [ADDR_W-1:0]      addr_reg,
	output logic [MISC_W-1:0]      misc_reg
);
	//------------------------------------------------------------
	// Next values
	//------------------------------------------------------------
	wire logic              was_valid = status_reg[ST_VALID];
	wire logic              take      = log_en && !was_valid;
	wire logic              overflow  = log_en && was_valid;
	wire logic [STAT_W-1:0] fresh;
	assign fresh = {1'b1, 1'b0, rpt.uncorr, rpt.misc_ok, rpt.addr_ok,
		rpt.context_corrupt, 2'h0, rpt.code};

	// New error wins over a clear in the same cycle
	wire logic [STAT_W-1:0] status_next =
		take     ? fresh :
		overflow ? (status_reg | (24'h1 << ST_OVER)) :
		clr      ? STAT_RST : status_reg;

	// Only the first error keeps its address and misc
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			status_reg <= STAT_RST;
			addr_reg   <= '0;
			misc_reg   <= '0;
		end else if (ce) begin
			status_reg <= status_next;
			if (take) begin
				addr_reg <= rpt.addr;
				misc_reg <= rpt.misc;
			end
		end
	end

	//------------------------------------------------------------
	// Checks
	//------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	bank_fill_a: assert property (ce && log_en && !was_valid |=>
		status_reg[ST_VALID] && addr_reg == $past(rpt.addr))
		else $error("bank did not take error");
	bank_over_a: assert property (ce && log_en && was_valid |=>
		status_reg[ST_OVER] && $stable(addr_reg))
		else $error("overflow not flagged");
	bank_clear_a: assert property (ce && clr && !log_en |=>
		status_reg == STAT_RST)
		else $error("bank clear failed");
	bank_over_c: cover property (ce && log_en && was_valid);
endmodule
`default_nettype wire

// file: mce_banks.sv
// Top: machine-check bank array with global status and shutdown
`timescale 1ns/1ps
`default_nettype none
module mce_banks
	import mce_pkg::*;
(
	// Clock, reset, enable
	input  wire logic                     CORE_CLK,
	input  wire logic                     ARST_N,
	input  wire logic                     CE,
	// Detected errors from the core
	input  wire logic                     ERR_VALID,
	input  wire logic [BANK_W-1:0]        ERR_BANK,
	input  wire err_rpt_t                 ERR_RPT,
	input  wire ctx_t                     ERR_CTX,
	// Machine check enable
	input  wire logic                     CHECK_EXCEPTION_ENABLE,
	// Software writes
	input  wire logic                     GSTAT_WR,
	input  wire logic [GSTAT_W-1:0]       GSTAT_WDATA,
	input  wire logic                     BANK_CLR,
	input  wire logic [BANK_W-1:0]        BANK_SEL,
	// Software reads
	output logic [GSTAT_W-1:0]            GLOBAL_CHECK_STATUS,
	output logic [7:0]                    CHECK_CAPABILITY,
	output logic [NUM_BANKS*STAT_W-1:0]   BANK_ERROR_STATUS,
	output logic [NUM_BANKS*ADDR_W-1:0]   BANK_ERROR_ADDRESS,
	output logic [NUM_BANKS*MISC_W-1:0]   BANK_ERROR_MISC,
	// Core control
	output logic                          CHECK_EXCEPTION,
	output logic                          SHUTDOWN
);
	//------------------------------------------------------------
	// Event decode
	//------------------------------------------------------------
	logic [GSTAT_W-1:0] gstat_reg;
	logic               exc_reg;
	logic               shut_reg;

	wire logic check_in_progress     = gstat_reg[GS_CHECK_IN_PROGRESS];
	// Correctable errors are logged silently
	wire logic raise    = ERR_VALID && ERR_RPT.uncorr
		&& CHECK_EXCEPTION_ENABLE && !shut_reg;
	// A second exception while one is open cannot nest
	wire logic recurse  = raise && check_in_progress;
	wire logic take_exc = raise && !check_in_progress;

	// Raising wins over a software write in the same cycle
	wire logic [GSTAT_W-1:0] gstat_next =
		take_exc ? {1'b1, ERR_CTX.eipv, ERR_CTX.restart_ip_valid} :
		GSTAT_WR ? GSTAT_WDATA : gstat_reg;

	//------------------------------------------------------------
	// Global state
	//------------------------------------------------------------
	// Shutdown is sticky; only reset leaves it
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			gstat_reg <= GSTAT_RST;
			exc_reg   <= 1'b0;
			shut_reg  <= 1'b0;
		end else if (CE) begin
			gstat_reg <= gstat_next;
			exc_reg   <= take_exc;
			shut_reg  <= shut_reg | recurse;
		end
	end

	assign GLOBAL_CHECK_STATUS = gstat_reg;
	assign CHECK_CAPABILITY    = CAP_COUNT;
	assign CHECK_EXCEPTION     = exc_reg;
	assign SHUTDOWN            = shut_reg;

	//------------------------------------------------------------
	// Banks
	//------------------------------------------------------------
	// Bank clears never touch global status
	for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
		wire logic hit = ERR_VALID && ERR_BANK == BANK_W'(b);
		wire logic clr = BANK_CLR && BANK_SEL == BANK_W'(b);
		mce_bank u_bank (
			.clk        (CORE_CLK),
			.arst_n     (ARST_N),
			.ce         (CE),
			.log_en     (hit),
			.rpt        (ERR_RPT),
			.clr        (clr),
			.status_reg (BANK_ERROR_STATUS[b*STAT_W +: STAT_W]),
			.addr_reg   (BANK_ERROR_ADDRESS[b*ADDR_W +: ADDR_W]),
			.misc_reg   (BANK_ERROR_MISC[b*MISC_W +: MISC_W])
		);
	end

	//------------------------------------------------------------
	// Checks
	//------------------------------------------------------------
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!ARST_N);

	check_in_progress_set_a: assert property (CE && take_exc |=>
		GLOBAL_CHECK_STATUS[GS_CHECK_IN_PROGRESS] && CHECK_EXCEPTION)
		else $error("in-progress not set on exception");
	recur_shut_a: assert property (CE && raise && check_in_progress |=>
		SHUTDOWN)
		else $error("recursion did not shut down");
	corr_quiet_a: assert property (CE && ERR_VALID && !ERR_RPT.uncorr
		|=> !CHECK_EXCEPTION)
		else $error("correctable error raised exception");
	// Bank traffic in the same cycle may change banks legally
	check_in_progress_clr_a: assert property (CE && GSTAT_WR && GSTAT_WDATA == '0
		&& !take_exc && !ERR_VALID && !BANK_CLR
		|=> GLOBAL_CHECK_STATUS == '0
		&& $stable(BANK_ERROR_STATUS))
		else $error("global clear wrong");
	cap_count_a: assert property (CHECK_CAPABILITY == 8'(NUM_BANKS))
		else $error("bank count wrong");
	shut_hold_a: assert property (SHUTDOWN |=> SHUTDOWN[*2])
		else $error("shutdown released");

	exc_c:   cover property (CE && take_exc);
	recur_c: cover property (CE && recurse);
	corr_c:  cover property (CE && ERR_VALID && !ERR_RPT.uncorr);
endmodule
`default_nettype wire

// file: tb.sv
// Self-checking bench for the machine-check bank array
`timescale 1ns/1ps
`default_nettype none
module tb;
	import mce_pkg::*;
	//------------------------------
	// Signals and model state
	//------------------------------
	logic                        clk, rst_n, ce, ev, en, gwr, clr;
	logic                        exc_o, shd_o, exc, shd;
	logic [BANK_W-1:0]           eb, sel;
	logic [GSTAT_W-1:0]          gwd, gs_o, gs;
	logic [7:0]                  cap;
	logic [15:0]                 r;
	logic [NUM_BANKS*STAT_W-1:0] st_o;
	logic [NUM_BANKS*ADDR_W-1:0] ad_o;
	logic [NUM_BANKS*MISC_W-1:0] mi_o;
	logic [STAT_W-1:0]           st[NUM_BANKS];
	logic [ADDR_W-1:0]           ad[NUM_BANKS];
	logic [MISC_W-1:0]           mi[NUM_BANKS];
	err_rpt_t                    rpt;
	ctx_t                        ctx;
	int                          fail_count, check_count;
	int                          ts;
	int                          log_q[$];
	// Arbitrary identifier of the core under test
	localparam int               CPU_ID = 1;

	// Device under test
	mce_banks dut (
		.CORE_CLK(clk), .ARST_N(rst_n), .CE(ce), .ERR_VALID(ev),
		.ERR_BANK(eb), .ERR_RPT(rpt), .ERR_CTX(ctx),
		.CHECK_EXCEPTION_ENABLE(en), .GSTAT_WR(gwr), .GSTAT_WDATA(gwd),
		.BANK_CLR(clr), .BANK_SEL(sel), .GLOBAL_CHECK_STATUS(gs_o),
		.CHECK_CAPABILITY(cap), .BANK_ERROR_STATUS(st_o),
		.BANK_ERROR_ADDRESS(ad_o), .BANK_ERROR_MISC(mi_o),
		.CHECK_EXCEPTION(exc_o), .SHUTDOWN(shd_o));

	// 10 MHz core clock
	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end

	//------------------------------
	// Model, compare and drive tasks
	//------------------------------
	function automatic logic [15:0] lfsr(logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic check_all;
		for (int b = 0; b < NUM_BANKS; b++) begin
			chk("status", 32'(st[b]), 32'(st_o[b*STAT_W+:STAT_W]));
			chk("address", ad[b], ad_o[b*ADDR_W+:ADDR_W]);
			chk("misc", mi[b], mi_o[b*MISC_W+:MISC_W]);
		end
		chk("global", 32'(gs), 32'(gs_o));
		chk("capability", 32'(NUM_BANKS), 32'(cap));
		chk("exception", 32'(exc), 32'(exc_o));
		chk("shutdown", 32'(shd), 32'(shd_o));
	endtask

	// Next state at the edge; a full bank only gains overflow
	// In-progress is judged on the value before this edge's write
	task automatic model;
		logic busy;
		if (!ce)
			return;
		busy = gs[GS_CHECK_IN_PROGRESS];
		exc = 1'h0;
		if (gwr) gs = gwd;
		// An error on the same bank beats the clear
		if (clr && !(ev && eb == sel)) st[sel] = STAT_RST;
		if (ev) begin
			if (rpt.uncorr && !shd && en && busy) shd = 1'h1;
			else if (rpt.uncorr && !shd && en) begin
				exc = 1'h1;
				gs = {1'h1, ctx.eipv, ctx.restart_ip_valid};
			end
			if (st[eb][ST_VALID]) st[eb][ST_OVER] = 1'h1;
			else begin
				st[eb] = {2'h2, rpt.uncorr, rpt.misc_ok, rpt.addr_ok,
					rpt.context_corrupt, 2'h0, rpt.code};
				ad[eb] = rpt.addr;
				mi[eb] = rpt.misc;
			end
		end
	endtask

	task automatic cyc;
		@(posedge clk);
		ts++;
		model();
		@(negedge clk);
		check_all();
	endtask

	// Drive one cycle of requests at the falling edge
	task automatic op(bit e, bit [1:0] b, bit u, bit c, bit w, bit [2:0] d);
		r = lfsr(r);
		{ev, eb, sel, clr, gwr, gwd} = {e, b, b, c, w, d};
		rpt = {u, r[2:0], r, r, ~r, ~r, r};
		ctx = ctx_t'(r[4:3]);
		cyc();
	endtask

	task automatic do_reset;
		{rst_n, ev, clr, gwr} = 4'h0;
		foreach (st[b]) begin
			st[b] = STAT_RST;
			ad[b] = '0;
			mi[b] = '0;
		end
		{gs, exc, shd} = {GSTAT_RST, 2'h0};
		repeat (8) @(negedge clk);
		rst_n = 1'h1;
		cyc();
	endtask

	// Logging pass over all banks; stops at a context that cannot restart
	task automatic poll_banks(output bit ok, output bit clean);
		logic [STAT_W-1:0] s;
		bit                exp_ok;
		ok = 1'b1;
		clean = 1'b1;
		ce = 1'h1;
		for (int b = 0; b < NUM_BANKS; b++) begin
			s = st_o[b*STAT_W+:STAT_W];
			chk("poll status", 32'(st[b]), 32'(s));
			if (s[ST_VALID]) begin
				if (s[ST_ADDRESS_VALID])
					chk("log address", ad[b], ad_o[b*ADDR_W+:ADDR_W]);
				if (s[ST_MISC_VALID])
					chk("log misc", mi[b], mi_o[b*MISC_W+:MISC_W]);
				ok = !(gs_o[GS_CHECK_IN_PROGRESS] && s[ST_PCC] && !gs_o[GS_RESTART_IP_VALID]);
				exp_ok = !(gs[GS_CHECK_IN_PROGRESS] && st[b][ST_PCC] && !gs[GS_RESTART_IP_VALID]);
				clean = clean && !s[ST_PCC];
				chk("restart", 32'(exp_ok), 32'(ok));
				if (!ok)
					return;
				log_q.push_back(ts);
				log_q.push_back(CPU_ID);
				op(0, 2'(b), 0, 1, 0, 0);
				s = st_o[b*STAT_W+:STAT_W];
				chk("cleared", 32'(st[b][ST_VALID]), 32'(s[ST_VALID]));
			end
		end
	endtask

	// Exception handler: log, then resume or abort by reset
	task automatic handle;
		bit ok, clean;
		poll_banks(ok, clean);
		if (ok && clean && gs_o[GS_RESTART_IP_VALID])
			op(0, 0, 0, 0, 1, 0);
		else
			do_reset();
	endtask

	task automatic report_and_stop;
		$display("Checks %0d, mismatches %0d, logged %0d",
			check_count, fail_count, log_q.size());
		if (fail_count == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	//------------------------------
	// Main sequence and watchdog
	//------------------------------
	initial begin
		bit ok, clean;
		{ce, en, eb, sel, gwd, rpt, ctx} = '0;
		{ce, en} = 2'h3;
		r = 16'h000C;
		ts = 0;
		{fail_count, check_count} = '0;
		do_reset();
		op(1, 0, 1, 0, 0, 0); // Exception raised
		op(1, 1, 0, 0, 0, 0); // Corrected, none
		op(1, 0, 0, 0, 0, 0); // Second on full bank
		op(0, 0, 0, 0, 1, 0); // Flag cleared
		en = 1'h0;
		op(1, 2, 1, 0, 0, 0); // Disabled, logged only
		// Older-core style report: error type and address of the bank
		chk("legacy type", 32'(st[2][ST_CODE_LO+:CODE_W]),
			32'(st_o[2*STAT_W+ST_CODE_LO+:CODE_W]));
		chk("legacy address", ad[2], ad_o[2*ADDR_W+:ADDR_W]);
		en = 1'h1;
		op(0, 0, 0, 1, 0, 0); // Bank zeroed
		op(1, 0, 1, 0, 0, 0); // Refilled
		op(1, 3, 1, 0, 0, 0); // Recursion
		op(1, 1, 1, 0, 0, 0); // No exception now
		ce = 1'h0;
		op(1, 2, 1, 0, 0, 0); // Frozen state
		op(0, 2, 0, 1, 0, 0); // Frozen state
		ce = 1'h1;
		// Random traffic; clock enable dropped only between pulses
		repeat (4) begin
			do_reset();
			for (int i = 0; i < 100; i++) begin
				r = lfsr(r);
				ce = (r[7:5] != 3'h0) || exc;
				op(ce && r[9:8] == 2'h1, r[11:10], r[12],
					ce && r[9:8] == 2'h2, ce && r[9:8] == 2'h3,
					{&r[15:13], r[14:13]});
				// Some exceptions are left open so recursion stays reachable
				if (exc && r[0])
					handle();
				if (i % 16 == 15)
					poll_banks(ok, clean);
			end
		end
		report_and_stop();
	end

	// Run needs well under 1500 cycles; cut off at 3000
	initial begin
		#300000;
		fail_count++;
		report_and_stop();
	end
endmodule
`default_nettype wire
